// ---- evs_pkg.sv ----
// Constants and types for the exception vector select unit.
// Assumes one core clock and a 32-bit APB register bus.
`default_nettype none
package evs_pkg;
    // Vector offsets
    localparam logic [15:0] VEC_RSVD0  = 16'h0000;
    localparam logic [15:0] VEC_RESET  = 16'h0100;
    localparam logic [15:0] VEC_MCHK   = 16'h0200;
    localparam logic [15:0] VEC_DACC   = 16'h0300;
    localparam logic [15:0] VEC_IACC   = 16'h0400;
    localparam logic [15:0] VEC_EXT    = 16'h0500;
    localparam logic [15:0] VEC_ALIGN  = 16'h0600;
    localparam logic [15:0] VEC_PROG   = 16'h0700;
    localparam logic [15:0] VEC_FPU    = 16'h0800;
    localparam logic [15:0] VEC_CDOWN  = 16'h0900;
    localparam logic [15:0] VEC_IOERR  = 16'h0a00;
    localparam logic [15:0] VEC_RSVD_B = 16'h0b00;
    localparam logic [15:0] VEC_SCALL  = 16'h0c00;
    localparam logic [15:0] VEC_RSVD_E = 16'h0e00;
    localparam logic [15:0] VEC_RUN    = 16'h2000;
    // Register byte offsets
    localparam logic [7:0] A_STATE   = 8'h00;
    localparam logic [7:0] A_RUNCFG  = 8'h04;
    localparam logic [7:0] A_IMATCH  = 8'h08;
    localparam logic [7:0] A_DBRK    = 8'h0c;
    localparam logic [7:0] A_EXTCTL  = 8'h10;
    localparam logic [7:0] A_FSTAT   = 8'h14;
    localparam logic [7:0] A_CDOWN   = 8'h18;
    localparam logic [7:0] A_DFCAUSE = 8'h1c;
    localparam logic [7:0] A_SAVED   = 8'h20;
    localparam logic [7:0] A_STATUS  = 8'h24;
    // machine_state_reg field positions
    localparam int MS_EXT_MASK = 0;
    localparam int MS_USER     = 1;
    localparam int MS_FLOAT    = 2;
    localparam int MS_CHECK    = 3;
    localparam int MS_FPM0     = 4;
    localparam int MS_FPM1     = 5;
    localparam int MS_STEP     = 6;
    localparam int MS_LITTLE   = 7;
    // Pin synchroniser lanes
    localparam int PIN_ERR = 2;
    localparam int PIN_INT = 3;
    // Exception classes
    typedef enum logic [1:0] {
        CL_NONE      = 2'b00,
        CL_ASYNC_IMP = 2'b01,
        CL_ASYNC_PRE = 2'b10,
        CL_SYNC_PRE  = 2'b11
    } evs_class_t;
    // Run modes held in run_mode_config
    typedef enum logic [1:0] {
        RUN_NORMAL = 2'b00,
        RUN_STEP   = 2'b01,
        RUN_LIMIT  = 2'b10,
        RUN_RSVD   = 2'b11
    } evs_run_t;
    // Conditions reported by the pipeline for the instruction at pc
    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [31:0] ea;
        logic        if_noxl;
        logic        if_io;
        logic        if_prot;
        logic        d_acc;
        logic        d_noxl;
        logic        d_prot;
        logic        d_rsv_io;
        logic        d_store;
        logic        ext_ctl_op;
        logic        float_io;
        logic        lsx_page;
        logic        prot_cross;
        logic        mw_cross;
        logic        dcbz_wtci;
        logic        misalign;
        logic        strmul;
        logic        float_insn;
        logic        fsum_insn;
        logic        mtfs_both;
        logic        sreg_op;
        logic        sreg_bad;
        logic [9:0]  special_reg_number;
        logic        illegal;
        logic        trap_hit;
        logic        system_call_op;
        logic        io_fail;
        logic        io_mem;
        logic        branch;
    } evs_pipe_t;
    // Whole register state of the unit
    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [7:0]  ms;
        evs_run_t    run;
        logic [31:0] imatch;
        logic [31:0] dbrk;
        logic        ext_en;
        logic        fsum;
        logic [31:0] cdown;
        logic        cdown_pend;
        logic        ext_pend;
        logic [5:0]  dfc;
        logic [3:0]  prog;
        logic [31:0] saved;
        logic [15:0] vec;
        evs_class_t  cls;
        logic        take;
        logic        chkstop;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } evs_state_t;
endpackage : evs_pkg
`default_nettype wire

// ---- evs_exception_select.sv ----
// Exception recognition and vector selection for the core.
// Assumes pipeline conditions arrive on pclk; pins are asynchronous.
// Function
// - Every exception is async imprecise, async precise or sync precise.
// - Soft or hard reset pin raises system reset at 00100.
// - Transfer error acknowledge raises machine check at 00200.
// - Data access at 00300 records each fault cause in its own bit.
// - Untranslatable, I/O or protected fetch vectors to 00400.
// - External interrupt request pin raises exception at 00500.
// - Listed boundary and I/O segment cases raise alignment at 00600.
// - Block zero on write-through or inhibited page raises alignment.
// - Little-endian misalignment or string/multiple raises alignment.
// - Enabled float condition raises program at 00700, cause saved.
// - Summary bit set by any float exception or status move.
// - User access to invalid special register with top bit set.
// - Illegal or unimplemented instruction raises program exception.
// - Trap with any condition met raises program exception.
// - Float instruction with float unit disallowed vectors to 00800.
// - Countdown top bit rising 0 to 1 raises exception at 00900.
// - Failed I/O reply from controller vectors to 00A00.
// - I/O error on memory access saves the next instruction address.
// - System call instruction vectors to 00C00.
// - Run mode at 02000 follows config; step breaks after each one.
// - Limited compare breaks when decoded address matches; skip branch/float.
// - Step enable bit traces through 02000; reserved vectors never used.
// - External and countdown held while masked; mask cleared on take.
// - Machine check with check enable clear enters checkstop.
// - Reset first, machine check second, both preempt everything.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module evs_exception_select
    import evs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        soft_reset_pin,
    input  wire logic        hard_reset_pin,
    input  wire logic        transfer_error_ack,
    input  wire logic        ext_int_req,
    input  wire evs_pipe_t   pipe,
    output logic             take_strobe,
    output logic      [15:0] vector_offset,
    output evs_class_t       exc_class,
    output logic      [31:0] saved_return_addr,
    output logic             checkstop
);

    evs_state_t  r;
    evs_state_t  next_r;
    logic        rst_ev;
    logic        mc_ev;
    logic        v;
    logic        brk_hit;
    logic [5:0]  df;
    logic        dacc;
    logic        align;
    logic        fpen;
    logic [3:0]  prg;
    logic        fpu;
    logic        lim;
    logic        step;
    logic        go;
    logic [15:0] vsel;
    evs_class_t  csel;
    logic [31:0] sav;

    // Address of the instruction after pc
    function automatic logic [31:0] next_pc(input logic [31:0] pc);
        next_pc = pc + 32'h4;
    endfunction : next_pc

    // Outputs straight from the state register
    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
    assign take_strobe       = r.take;
    assign vector_offset     = r.vec;
    assign exc_class         = r.cls;
    assign saved_return_addr = r.saved;
    assign checkstop         = r.chkstop;

    // Whole next-state computation
    always_comb begin
        next_r = r;
        next_r.take = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        go = 1'b0;
        vsel = VEC_RESET;
        csel = CL_NONE;
        sav = pipe.pc;

        // Pins pass two flops, third stage is edge history
        next_r.s1 = {ext_int_req, transfer_error_ack,
                     hard_reset_pin, soft_reset_pin};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // Edge detection keeps a held pin from retriggering
        rst_ev = |(r.s2[1:0] & ~r.s3[1:0]);
        mc_ev = r.s2[PIN_ERR] & ~r.s3[PIN_ERR];

        // Countdown runs every cycle unless software loads it
        next_r.cdown = r.cdown - 32'h1;

        // APB setup phase: latch read data, answer next cycle
        if (psel && !penable) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                A_STATE:   next_r.prdata = {24'h000000, r.ms};
                A_RUNCFG:  next_r.prdata = {30'h0, r.run};
                A_IMATCH:  next_r.prdata = r.imatch;
                A_DBRK:    next_r.prdata = r.dbrk;
                A_EXTCTL:  next_r.prdata = {31'h0, r.ext_en};
                A_FSTAT:   next_r.prdata = {31'h0, r.fsum};
                A_CDOWN:   next_r.prdata = r.cdown;
                A_DFCAUSE: next_r.prdata = {26'h0, r.dfc};
                A_SAVED:   next_r.prdata = r.saved;
                A_STATUS:  next_r.prdata = {7'h00, r.chkstop,
                                            r.ext_pend, r.cdown_pend,
                                            r.prog, r.cls, r.vec};
                default:   next_r.pslverr = 1'b1;
            endcase
        end

        // APB access phase: writes land at the completing edge
        if (psel && penable && r.pready && pwrite && !r.pslverr) begin
            case (paddr)
                A_STATE:  next_r.ms = pwdata[7:0];
                A_RUNCFG: next_r.run = evs_run_t'(pwdata[1:0]);
                A_IMATCH: next_r.imatch = pwdata;
                A_DBRK:   next_r.dbrk = pwdata;
                A_EXTCTL: next_r.ext_en = pwdata[0];
                A_FSTAT:  next_r.fsum = pwdata[0];
                A_CDOWN:  next_r.cdown = pwdata;
                default:  ;
            endcase
        end

        // Instruction conditions; none count while checkstopped
        v = pipe.valid & ~r.chkstop;
        brk_hit = pipe.d_acc & (r.dbrk[1:0] != 2'b00)
                & (pipe.ea[31:2] == r.dbrk[31:2])
                & (pipe.d_store ? r.dbrk[1] : r.dbrk[0]);
        // Each fault cause gets its own bit
        df = {pipe.d_noxl, pipe.d_prot, pipe.d_rsv_io,
              pipe.d_store, brk_hit,
              pipe.ext_ctl_op & ~r.ext_en};
        dacc = v & (|df[5:3] | |df[1:0]);
        // Alignment cases; little-endian ones only in that mode
        align = v & (pipe.float_io | pipe.lsx_page
                | pipe.prot_cross | pipe.mw_cross);
        align = align | (v & pipe.dcbz_wtci);
        align = align | (v & r.ms[MS_LITTLE]
                & (pipe.misalign | pipe.strmul));
        // Program causes; the summary bit gates the float cause
        fpen = (r.ms[MS_FPM0] | r.ms[MS_FPM1])
             & (r.fsum | pipe.fsum_insn);
        prg[3] = v & pipe.float_insn & fpen;
        prg[2] = v & pipe.illegal;
        prg[1] = v & pipe.sreg_op & pipe.sreg_bad
               & pipe.special_reg_number[9]
               & r.ms[MS_USER];
        prg[0] = v & pipe.trap_hit;
        // Float work while the unit is disallowed
        fpu = v & pipe.float_insn & ~r.ms[MS_FLOAT];
        // Limited compare cannot see branch or float work
        lim = v & (r.run == RUN_LIMIT)
            & (pipe.pc == r.imatch)
            & ~pipe.branch & ~pipe.float_insn;
        // Step mode and trace both break through the run vector
        step = v & ((r.run == RUN_STEP)
             | r.ms[MS_STEP]);

        // Priority chain, reset and machine check first
        if (rst_ev) begin
            go = 1'b1;
            vsel = VEC_RESET;
            csel = CL_ASYNC_IMP;
            next_r.chkstop = 1'b0;
        end else if (r.chkstop) begin
            go = 1'b0;
        end else if (mc_ev) begin
            if (r.ms[MS_CHECK]) begin
                go = 1'b1;
                vsel = VEC_MCHK;
                csel = CL_ASYNC_IMP;
            end else begin
                next_r.chkstop = 1'b1;
            end
        end else if (lim) begin
            go = 1'b1;
            vsel = VEC_RUN;
            csel = CL_SYNC_PRE;
        end else if (v & (pipe.if_noxl | pipe.if_io | pipe.if_prot)) begin
            go = 1'b1;
            vsel = VEC_IACC;
            csel = CL_SYNC_PRE;
        end else if (|prg) begin
            go = 1'b1;
            vsel = VEC_PROG;
            csel = CL_SYNC_PRE;
            next_r.prog = prg;
        end else if (fpu) begin
            go = 1'b1;
            vsel = VEC_FPU;
            csel = CL_SYNC_PRE;
        end else if (align) begin
            go = 1'b1;
            vsel = VEC_ALIGN;
            csel = CL_SYNC_PRE;
        end else if (dacc) begin
            go = 1'b1;
            vsel = VEC_DACC;
            csel = CL_SYNC_PRE;
            next_r.dfc = df;
        end else if (v & pipe.io_fail) begin
            go = 1'b1;
            vsel = VEC_IOERR;
            csel = CL_SYNC_PRE;
            if (pipe.io_mem) begin
                sav = next_pc(pipe.pc);
            end
        end else if (v & pipe.system_call_op) begin
            go = 1'b1;
            vsel = VEC_SCALL;
            csel = CL_SYNC_PRE;
            sav = next_pc(pipe.pc);
        end else if (step) begin
            go = 1'b1;
            vsel = VEC_RUN;
            csel = CL_SYNC_PRE;
            sav = next_pc(pipe.pc);
        end else if (r.ms[MS_EXT_MASK] && r.ext_pend) begin
            go = 1'b1;
            vsel = VEC_EXT;
            csel = CL_ASYNC_PRE;
            next_r.ext_pend = 1'b0;
        end else if (r.ms[MS_EXT_MASK] && r.cdown_pend) begin
            go = 1'b1;
            vsel = VEC_CDOWN;
            csel = CL_ASYNC_PRE;
            next_r.cdown_pend = 1'b0;
        end

        // Taking any exception masks and enters supervisor level
        if (go) begin
            next_r.take = 1'b1;
            next_r.vec = vsel;
            next_r.cls = csel;
            next_r.saved = sav;
            next_r.ms[MS_EXT_MASK] = 1'b0;
            next_r.ms[MS_USER] = 1'b0;
        end

        // Pending sets after the clears, so a new event wins
        if (r.s2[PIN_INT]) begin
            next_r.ext_pend = 1'b1;
        end
        if (!r.cdown[31] && next_r.cdown[31]) begin
            next_r.cdown_pend = 1'b1;
        end
        if (v && (pipe.fsum_insn || pipe.mtfs_both)) begin
            next_r.fsum = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Countdown top bit going from 0 to 1
    sequence s_cdown_rise;
        !r.cdown[31] ##1 r.cdown[31];
    endsequence

    // APB setup cycle
    sequence s_setup;
        psel && !penable;
    endsequence

    // Checks on each take and on what it leaves behind
    a_reset_vector: assert property (
        rst_ev |=> r.take && r.vec == VEC_RESET && r.cls == CL_ASYNC_IMP)
        else $error("reset edge did not vector to reset offset");

    a_mcheck_vector: assert property (
        mc_ev && !rst_ev && !r.chkstop && r.ms[MS_CHECK]
        |=> r.take && r.vec == VEC_MCHK)
        else $error("machine check not taken");

    a_checkstop_entry: assert property (
        mc_ev && !rst_ev && !r.ms[MS_CHECK] |=> r.chkstop && !r.take)
        else $error("checkstop not entered");

    a_reserved_vec: assert property (
        r.take |-> r.vec != VEC_RSVD0 && r.vec != VEC_RSVD_B
        && r.vec != VEC_RSVD_E)
        else $error("reserved vector used");

    a_mask_on_take: assert property (
        r.take |-> !r.ms[MS_EXT_MASK] && !r.ms[MS_USER])
        else $error("mask bit not cleared on take");

    a_ext_masked: assert property (
        !r.ms[MS_EXT_MASK]
        |=> !(r.take && (r.vec == VEC_EXT || r.vec == VEC_CDOWN)))
        else $error("masked async exception taken");

    a_cdown_pend: assert property (
        s_cdown_rise |-> r.cdown_pend)
        else $error("countdown rise not latched");

    a_fpu_cause: assert property (
        r.take && r.vec == VEC_FPU
        |-> $past(pipe.float_insn) && !$past(r.ms[MS_FLOAT]))
        else $error("float unavailable without cause");

    a_io_return: assert property (
        r.take && r.vec == VEC_IOERR && $past(pipe.io_mem)
        |-> r.saved == $past(pipe.pc) + 32'h4)
        else $error("io error return address wrong");

    a_take_pulse: assert property (
        r.take && r.cls == CL_SYNC_PRE |=> !r.take || r.cls != CL_SYNC_PRE
        || $past(pipe.valid))
        else $error("take strobe held without cause");

    a_apb_ready: assert property (
        s_setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    // Async precise takes report their own class
    a_async_class: assert property (
        r.take && (r.vec == VEC_EXT || r.vec == VEC_CDOWN) |-> r.cls == CL_ASYNC_PRE)
        else $error("async precise take with wrong class");

    // Only a reset edge leaves checkstop; nothing is taken meanwhile
    a_chkstop_hold: assert property (
        r.chkstop && !rst_ev |=> r.chkstop && !r.take)
        else $error("checkstop left without reset");

    // An illegal instruction is never dropped outside checkstop or a machine check edge
    a_illegal_take: assert property (
        pipe.valid && pipe.illegal && !r.chkstop && !mc_ev |=> r.take)
        else $error("illegal instruction not taken");

    // System call saves the address after the call
    a_scall_return: assert property (
        r.take && r.vec == VEC_SCALL |-> r.saved == $past(pipe.pc) + 32'h4)
        else $error("system call return address wrong");

endmodule : evs_exception_select

`default_nettype wire

// ---- evs_sys_partner.sv ----
// Model of the system logic that drives the reset, error and interrupt pins.
// Assumes the bench asks for one pin pulse at a time through kind and go.
`timescale 1ns/10ps
`default_nettype none
module evs_sys_partner
    import evs_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic [1:0] kind,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [3:0] hold,
    output logic            soft_reset_pin,
    output logic            hard_reset_pin,
    output logic            transfer_error_ack,
    output logic            ext_int_req
);
    logic [3:0] pins = 4'h0;
    // Lanes: 0 soft reset, 1 hard reset, then error and interrupt lanes
    assign soft_reset_pin     = pins[0];
    assign hard_reset_pin     = pins[1];
    assign transfer_error_ack = pins[PIN_ERR];
    assign ext_int_req        = pins[PIN_INT];
    // Each request waits if slow, raises one pin after an edge, holds it, then drops it
    always begin
        @(posedge pclk);
        if (go === 1'b1) begin
            repeat (slow ? 5 : 0) @(posedge pclk);
            pins[kind] <= 1'b1;
            repeat (hold) @(posedge pclk);
            pins[kind] <= 1'b0;
        end
    end
endmodule : evs_sys_partner
`default_nettype wire

// ---- test_exception_vector_select.sv ----
// Self-checking bench for the exception vector select unit.
// Assumes the pin partner model, a 10 MHz pclk and a wait-free APB slave.
`timescale 1ns/10ps
`default_nettype none
module test_exception_vector_select
    import evs_pkg::*;
;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    evs_pipe_t   pipe    = '0;
    logic [1:0]  kind    = 2'h0;
    logic        go      = 1'b0;
    logic        slow    = 1'b0;
    logic [3:0]  hold    = 4'h2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        srst;
    logic        hrst;
    logic        terr;
    logic        irq;
    logic        take_strobe;
    logic [15:0] vector_offset;
    evs_class_t  exc_class;
    logic [31:0] saved_return_addr;
    logic        checkstop;
    logic [31:0] r;
    logic        e;
    int          num_errors = 0;
    int          cmp_count  = 0;

    // Clock at 100 ns period
    always #50 pclk = ~pclk;

    evs_exception_select u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .soft_reset_pin(srst),
        .hard_reset_pin(hrst), .transfer_error_ack(terr), .ext_int_req(irq),
        .pipe(pipe), .take_strobe(take_strobe), .vector_offset(vector_offset),
        .exc_class(exc_class), .saved_return_addr(saved_return_addr),
        .checkstop(checkstop)
    );

    evs_sys_partner u_sys (
        .pclk(pclk), .kind(kind), .go(go), .slow(slow), .hold(hold),
        .soft_reset_pin(srst), .hard_reset_pin(hrst),
        .transfer_error_ack(terr), .ext_int_req(irq)
    );

    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                r = prdata;
                e = pslverr;
                break;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            num_errors++;
            conclude();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x,
                        input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(nm, x, r & m);
    endtask : rchk

    // Waits a bounded time for a take and checks what it presents
    task automatic take(input logic [15:0] ev, input evs_class_t ec, input logic [31:0] es,
                        input logic ck_s);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (take_strobe === 1'b1) break;
        end
        chk("take seen", 32'h1, (i < 40) ? 32'h1 : 32'h0);
        if (i == 40) conclude();
        chk("vector", {16'h0, ev}, {16'h0, vector_offset});
        chk("class", {30'h0, ec}, {30'h0, exc_class});
        if (ck_s) chk("saved", es, saved_return_addr);
        $display("take at %h done", ev);
    endtask : take

    // Counts takes over n cycles; none expected
    task automatic quiet(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (take_strobe !== 1'b0) c++;
        end
        chk("no take", 32'h0, c);
    endtask : quiet

    // One instruction with the chosen condition; ev 0 means no take expected
    task automatic sync(input int b, input logic [15:0] ev, input logic [31:0] so);
        evs_pipe_t p;
        p = '0;
        p.valid = 1'b1;
        p.pc = 32'h0000_2040;
        case (b)
            0: p.float_insn = 1'b1;
            1: p.illegal = 1'b1;
            2: p.trap_hit = 1'b1;
            3: p.system_call_op = 1'b1;
            4: {p.io_fail, p.io_mem} = 2'b11;
            5: p.if_noxl = 1'b1;
            6: p.if_io = 1'b1;
            7: p.if_prot = 1'b1;
            8: {p.d_acc, p.d_noxl, p.d_store} = 3'b111;
            9: {p.d_acc, p.ext_ctl_op} = 2'b11;
            10: p.float_io = 1'b1;
            11: p.lsx_page = 1'b1;
            12: p.prot_cross = 1'b1;
            13: p.mw_cross = 1'b1;
            14: p.dcbz_wtci = 1'b1;
            15: p.misalign = 1'b1;
            16: p.strmul = 1'b1;
            17: {p.sreg_op, p.sreg_bad, p.special_reg_number} = 12'he00;
            18: {p.illegal, p.system_call_op} = 2'b11;
            19: p.mtfs_both = 1'b1;
            default: p.valid = 1'b1;
        endcase
        @(posedge pclk);
        pipe <= p;
        @(posedge pclk);
        pipe <= '0;
        if (ev !== 16'h0) take(ev, CL_SYNC_PRE, p.pc + so, 1'b1);
    endtask : sync

    // Asks the partner for one pin pulse
    task automatic pin(input logic [1:0] k, input logic sl, input logic [3:0] h);
        @(posedge pclk);
        kind <= k;
        slow <= sl;
        hold <= h;
        go   <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
    endtask : pin

    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        chk("reset outs", 32'h0, {14'h0, checkstop, take_strobe, vector_offset});
        presetn <= 1'b1;
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        wr(A_CDOWN, 32'h7fff_ffff);
        wr(A_EXTCTL, 32'h0);
        wr(A_STATE, 32'h0d);
        repeat (12) @(posedge pclk);
        wr(A_STATE, 32'h0c);
        rchk("state", A_STATE, 32'h0c, 32'hff);
        sync(1, VEC_PROG, 0);
        sync(2, VEC_PROG, 0);
        sync(3, VEC_SCALL, 4);
        sync(4, VEC_IOERR, 4);
        for (int b = 5; b < 8; b++) sync(b, VEC_IACC, 0);
        sync(8, VEC_DACC, 0);
        rchk("fault cause", A_DFCAUSE, 32'h24, 32'h3f);
        wr(A_DBRK, 32'h1);
        sync(9, VEC_DACC, 0);
        rchk("fault cause", A_DFCAUSE, 32'h03, 32'h3f);
        for (int b = 10; b < 15; b++) sync(b, VEC_ALIGN, 0);
        sync(18, VEC_PROG, 0);
        $display("sync cases done");
        wr(A_STATE, 32'h08);
        sync(0, VEC_FPU, 0);
        wr(A_STATE, 32'h1c);
        wr(A_FSTAT, 32'h1);
        sync(0, VEC_PROG, 0);
        rchk("prog cause", A_STATUS, 32'h0020_0000, 32'h003c_0000);
        wr(A_STATE, 32'h0c);
        wr(A_FSTAT, 32'h0);
        sync(19, 16'h0, 0);
        quiet(6);
        rchk("summary", A_FSTAT, 32'h1, 32'h1);
        wr(A_STATE, 32'h0e);
        sync(17, VEC_PROG, 0);
        rchk("prog cause", A_STATUS, 32'h0008_0000, 32'h003c_0000);
        wr(A_STATE, 32'h8c);
        sync(15, VEC_ALIGN, 0);
        sync(16, VEC_ALIGN, 0);
        $display("float and mode cases done");
        wr(A_STATE, 32'h4c);
        sync(99, VEC_RUN, 4);
        wr(A_STATE, 32'h0c);
        wr(A_RUNCFG, 32'h1);
        sync(99, VEC_RUN, 4);
        wr(A_RUNCFG, 32'h0);
        sync(99, 16'h0, 0);
        quiet(6);
        wr(A_IMATCH, 32'h0000_2040);
        wr(A_RUNCFG, 32'h2);
        sync(99, VEC_RUN, 0);
        wr(A_RUNCFG, 32'h0);
        $display("run mode cases done");
        pin(2'd0, 1'b0, 4'h2);
        take(VEC_RESET, CL_ASYNC_IMP, 0, 1'b0);
        pin(2'd1, 1'b1, 4'h3);
        take(VEC_RESET, CL_ASYNC_IMP, 0, 1'b0);
        pin(2'(PIN_ERR), 1'b0, 4'h2);
        take(VEC_MCHK, CL_ASYNC_IMP, 0, 1'b0);
        wr(A_STATE, 32'h0c);
        pin(2'(PIN_INT), 1'b0, 4'h4);
        quiet(10);
        wr(A_STATE, 32'h0d);
        take(VEC_EXT, CL_ASYNC_PRE, 0, 1'b0);
        rchk("mask cleared", A_STATE, 32'h0, 32'h1);
        wr(A_CDOWN, 32'h3);
        quiet(10);
        rchk("cdown pending", A_STATUS, 32'h0040_0000, 32'h0040_0000);
        wr(A_STATE, 32'h0d);
        take(VEC_CDOWN, CL_ASYNC_PRE, 0, 1'b0);
        wr(A_STATE, 32'h04);
        pin(2'(PIN_ERR), 1'b0, 4'h2);
        quiet(10);
        chk("checkstop", 32'h1, {31'h0, checkstop});
        sync(1, 16'h0, 0);
        quiet(4);
        pin(2'd0, 1'b0, 4'h2);
        take(VEC_RESET, CL_ASYNC_IMP, 0, 1'b0);
        chk("checkstop", 32'h0, {31'h0, checkstop});
        $display("pin cases done");
        conclude();
    end

    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        conclude();
    end
endmodule : test_exception_vector_select
`default_nettype wire
